// >>> sim/pad_model.sv
// Pad side of the pin block: resolves each pad from the block's driver,
// an outside driver and a pull-up.
// Assumes the bench steers the outside driver at clock edges.
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic [31:0] pin_out, // Block output level
  input wire logic [31:0] pin_oe, // Block drives when high
  input wire logic [31:0] ext_en, // Outside driver active
  input wire logic [31:0] ext_val, // Outside driver level
  output logic [31:0] pad // Resolved pad level
);
  // Block wins, then the outside driver; an undriven pad falls to the pull-up, never a stale value
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      pad[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
  end
endmodule // pad_model
`default_nettype wire

// >>> sim/tb.sv
// Bench for the pin block: reads checked through an expectation queue,
// pad and interrupt levels checked in place.
// Assumes the pad model beside the block and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] v;} note_s;
  logic clk = 1'b0; // System clock
  logic nrst = 1'b0; // Reset, active low
  pin_io_pkg::bus_req_s rq = '0; // Bus request
  logic [31:0] ext_en = '0, ext_val = '0, p_out = '0, p_oe = '0; // Far side stimulus
  logic [31:0] rdata, pout, poe, pad, p_in; // Observed
  logic wreq, irq; // Observed
  int fail_count = 0; // Mismatches
  int n_checks = 0; // Comparisons made
  logic [15:0] lfsr = 16'hc054; // Random source
  note_s notes[$]; // Expected reads, oldest first
  always #5 clk = ~clk;
  pin_io_data_irq_control i_pin_io_data_irq_control (.SYS_CLK(clk), .NRST(nrst),
    .AVS_ADDRESS(rq.address), .AVS_READ(rq.read), .AVS_WRITE(rq.write),
    .AVS_BYTEENABLE(rq.byteenable), .AVS_WRITEDATA(rq.writedata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .PIN_IN(pad), .PIN_OUT(pout), .PIN_OE(poe),
    .PERIPH_OUT(p_out), .PERIPH_OE(p_oe), .PERIPH_IN(p_in), .IRQ(irq));
  pad_model i_pad_model (.pin_out(pout), .pin_oe(poe), .ext_en(ext_en),
    .ext_val(ext_val), .pad(pad));
  // Sixteen-bit shift register, widened to a word
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return {lfsr, ~lfsr};
  endfunction
  // Compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // One transfer, entered just after a rising edge; held until waitrequest is low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m = 32'hffff_ffff);
    int n = 0;
    if (rd)
      notes.push_back('{a, m, d});
    rq <= '{a, rd, !rd, 4'hf, rd ? 32'h0 : d};
    // The answer edge is the rising edge that samples waitrequest low
    do @(posedge clk); while (wreq !== 1'b0 && ++n < 50);
    rq <= '0;
    @(posedge clk);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Takes the oldest note whenever a read is answered
  always @(posedge clk)
    if (rq.read && wreq === 1'b0)
    begin
      note_s t;
      t = notes.pop_front();
      chk($sformatf("reg %h", t.a), t.v & t.m, rdata & t.m);
    end
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] a, b;
    a = rnd();
    b = rnd();
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1, pin_io_pkg::OFF_OUT_STATE, 0);
    bus(1, pin_io_pkg::OFF_IRQ_MASK, 0);
    bus(1, 8'h1c, 0);
    bus(0, pin_io_pkg::OFF_OUT_SET, a);
    bus(0, pin_io_pkg::OFF_OUT_STATE, 32'hffff_ffff);
    bus(1, pin_io_pkg::OFF_OUT_STATE, a);
    bus(0, pin_io_pkg::OFF_OUT_CLR, b);
    bus(0, pin_io_pkg::OFF_OUT_CLR, 0);
    bus(1, pin_io_pkg::OFF_OUT_STATE, a & ~b);
    // Peripheral owns every pad: drive enable is only stored
    p_oe <= a;
    p_out <= b;
    bus(0, pin_io_pkg::OFF_DRIVE_EN, 32'hffff_ffff);
    cyc(5);
    chk("pin_oe", a, poe);
    chk("periph_in", (a & b) | ~a, p_in);
    bus(0, pin_io_pkg::OFF_CTRL_SEL_EN, 32'hffff_ffff);
    cyc(5);
    chk("pin_oe", 32'hffff_ffff, poe);
    chk("pin_out", a & ~b, pout);
    chk("periph_in", 0, p_in);
    // Release pads to the outside driver and read them back
    bus(0, pin_io_pkg::OFF_DRIVE_DIS, 32'hffff_ffff);
    ext_en <= 32'hffff_ffff;
    ext_val <= a;
    cyc(4);
    bus(1, pin_io_pkg::OFF_PIN_STATE, a);
    bus(1, pin_io_pkg::OFF_CHG_STATUS, 0, 0);
    bus(0, pin_io_pkg::OFF_IRQ_EN, 32'h0000_00ff);
    bus(1, pin_io_pkg::OFF_IRQ_MASK, 32'h0000_00ff);
    ext_val <= a ^ 32'h0000_0201;
    cyc(6);
    chk("irq", 1, {31'h0, irq});
    bus(1, pin_io_pkg::OFF_CHG_STATUS, 32'h0000_0201);
    bus(1, pin_io_pkg::OFF_CHG_STATUS, 0);
    chk("irq", 0, {31'h0, irq});
    bus(0, pin_io_pkg::OFF_IRQ_DIS, 32'h1);
    bus(1, pin_io_pkg::OFF_IRQ_MASK, 32'h0000_00fe);
    ext_val <= a;
    cyc(6);
    chk("irq", 0, {31'h0, irq});
    bus(1, pin_io_pkg::OFF_CHG_STATUS, 32'h1, 32'h1);
    // Filter select, then a one-cycle pulse on a filtered and an open pin
    bus(0, pin_io_pkg::OFF_FILTER_EN, 32'h0000_00f0);
    bus(0, pin_io_pkg::OFF_FILTER_DIS, 32'h0000_0030);
    bus(0, pin_io_pkg::OFF_FILTER_DIS, 0);
    bus(1, pin_io_pkg::OFF_FILTER_STATE, 32'h0000_00c0);
    bus(1, pin_io_pkg::OFF_CHG_STATUS, 0, 0);
    ext_val <= a ^ 32'h0000_00a0;
    @(posedge clk);
    ext_val <= a;
    cyc(6);
    bus(1, pin_io_pkg::OFF_CHG_STATUS, 32'h0000_0020);
    // Open drain: a one releases the pad, a zero drives it
    bus(0, pin_io_pkg::OFF_DRIVE_EN, 32'h4);
    bus(0, pin_io_pkg::OFF_OD_EN, 32'h4);
    bus(0, pin_io_pkg::OFF_OUT_SET, 32'h4);
    cyc(2);
    chk("oe_2", 0, {31'h0, poe[2]});
    bus(0, pin_io_pkg::OFF_OUT_CLR, 32'h4);
    cyc(2);
    chk("oe_2", 1, {31'h0, poe[2]});
    cyc(2);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire

// >>> src/pin_io_data_irq_control.sv
// Parallel I/O pin block: control select, output enable, glitch filter,
// set/clear output data, pin readback, change detect with mask, open drain.
// Assumes pins and peripheral signals synchronous to SYS_CLK, Avalon-MM
// master that holds requests until waitrequest is low.
//
// Function
// - Filter-disable one bit turns pin filter off
// - Filter status reads selected filters, tracks writes
// - Filter acts on peripheral and I/O input; pin status reads the unfiltered synchronised level
// - Set-output one sets latch; pin follows conditionally
// - Clear-output one clears latch; zero ignored
// - Output data status returns latch, resets zero
// - Pin status returns actual pin levels always
// - Irq-enable one enables change interrupt per pin
// - Irq-disable masks; detection continues regardless
// - Mask register reflects enables, resets zero
// - Status bit set on any edge
// - Status clears on read and reset
// - Open-drain enable one makes driver open drain
// - I/O control holds peripheral input at zero
// - Output enable stored, effective only under I/O
`timescale 1ns/1ps
`default_nettype none
module pin_io_data_irq_control #(
  parameter int unsigned PINS = 32 // Number of pins, fixed at 32 by the map
) (
  input wire logic SYS_CLK, // System clock, 100 MHz
  input wire logic NRST, // Synchronous reset, active low
  input wire logic [7:0] AVS_ADDRESS, // Byte address
  input wire logic AVS_READ, // Read strobe
  input wire logic AVS_WRITE, // Write strobe
  input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes of a write
  input wire logic [31:0] AVS_WRITEDATA, // Write data
  output logic [31:0] AVS_READDATA, // Read data, registered
  output logic AVS_WAITREQUEST, // Wait until answer is ready
  input wire logic [31:0] PIN_IN, // Level seen on each pad
  output logic [31:0] PIN_OUT, // Output level towards each pad
  output logic [31:0] PIN_OE, // Pad driver enable, high drives
  input wire logic [31:0] PERIPH_OUT, // Peripheral output data
  input wire logic [31:0] PERIPH_OE, // Peripheral output enable
  output logic [31:0] PERIPH_IN, // Filtered input to peripherals
  output logic IRQ // Change interrupt, level
);

  // All state of the block in one struct. Keeping every flop in a single
  // record lets one combinational process describe the whole next state and
  // one clocked process register it, so nothing can be missed at reset.
  // Per-pin vectors hold bit n for pin n throughout.
  typedef struct packed {
    logic [31:0] ctrl_sel_r; // 1 = parallel I/O owns the pin
    logic [31:0] drive_en_r; // Output enable latch
    logic [31:0] filter_r; // Filter selected
    logic [31:0] out_data_r; // Output data latch
    logic [31:0] od_r; // Open drain selected
    logic [31:0] mask_r; // Interrupt mask
    logic [31:0] chg_r; // Change status, sticky
    logic [31:0] sync1_r; // First synchroniser stage
    logic [31:0] sync2_r; // Second synchroniser stage
    logic [31:0] prev_r; // Previous synchronised sample
    logic [31:0] filt_r; // Filtered input
    logic [31:0] filt_prev_r; // Selected input path one cycle back
    logic [31:0] pin_out_r; // Pad output
    logic [31:0] pin_oe_r; // Pad enable
    logic [31:0] periph_in_r; // Peripheral input
    logic [31:0] rdata_r; // Read data
    logic ack_r; // Answer ready
    logic irq_r; // Interrupt output
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic wr_hit; // Write accepted this cycle
  logic rd_hit; // Read accepted this cycle
  logic rd_take; // Read seen while waiting: data captured now
  logic [31:0] wmask; // Write data gated by byte enables
  logic [31:0] filt_in; // Input path after optional filter

  // A request completes in the cycle after it rises: ack ends the wait
  assign wr_hit = AVS_WRITE && st_r.ack_r;
  assign rd_hit = AVS_READ && st_r.ack_r;
  // Read data is captured on the edge that lifts the wait, so it stands
  // in the one answer cycle and is sampled with waitrequest low
  assign rd_take = AVS_READ && !st_r.ack_r;

  // Byte lanes expand to a bit mask; disabled lanes write nothing
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign wmask[g*8 +: 8] = AVS_WRITEDATA[g*8 +: 8] & {8{AVS_BYTEENABLE[g]}};
    end
  endgenerate

  // Filter output or raw synchronised level, per pin
  assign filt_in = (st_r.filter_r & st_r.filt_r) | (~st_r.filter_r & st_r.sync2_r);

  // Next-state logic for the whole block.
  // Order matters below: the pad path, then the handshake, then register
  // writes, then the read capture and last the change status, which clears
  // from the registered read data, not from the capture made this cycle.
  // Everything starts from a copy of the current state, so a field that
  // no branch touches simply holds its value.
  always_comb
  begin
    st_nxt = st_r;
    // Two-stage synchroniser; first stage feeds only the second
    st_nxt.sync1_r = PIN_IN;
    st_nxt.sync2_r = st_r.sync1_r;
    st_nxt.prev_r = st_r.sync2_r;
    // Filter: accept a new level only after two equal samples
    st_nxt.filt_r = (st_r.sync2_r & st_r.prev_r) |
                    (st_r.filt_r & (st_r.sync2_r | st_r.prev_r));
    st_nxt.filt_prev_r = filt_in;
    // Peripheral sees filtered input, zero while I/O owns the pin
    st_nxt.periph_in_r = filt_in & ~st_r.ctrl_sel_r;
    // Pad drive: I/O owner uses its latches, else the peripheral
    for (int i = 0; i < 32; i++)
    begin
      if (st_r.ctrl_sel_r[i])
      begin
        st_nxt.pin_out_r[i] = st_r.out_data_r[i];
        st_nxt.pin_oe_r[i] = st_r.drive_en_r[i] &&
                             !(st_r.od_r[i] && st_r.out_data_r[i]);
      end
      else
      begin
        st_nxt.pin_out_r[i] = PERIPH_OUT[i];
        st_nxt.pin_oe_r[i] = PERIPH_OE[i] && !(st_r.od_r[i] && PERIPH_OUT[i]);
      end
    end
    // Handshake: ack goes high one cycle after a request, then drops
    st_nxt.ack_r = (AVS_READ || AVS_WRITE) && !st_r.ack_r;
    // Register writes
    if (wr_hit)
    begin
      unique case (AVS_ADDRESS)
        pin_io_pkg::OFF_CTRL_SEL_EN: st_nxt.ctrl_sel_r = st_r.ctrl_sel_r | wmask;
        pin_io_pkg::OFF_CTRL_SEL_DIS: st_nxt.ctrl_sel_r = st_r.ctrl_sel_r & ~wmask;
        pin_io_pkg::OFF_DRIVE_EN: st_nxt.drive_en_r = st_r.drive_en_r | wmask;
        pin_io_pkg::OFF_DRIVE_DIS: st_nxt.drive_en_r = st_r.drive_en_r & ~wmask;
        pin_io_pkg::OFF_FILTER_EN: st_nxt.filter_r = st_r.filter_r | wmask;
        pin_io_pkg::OFF_FILTER_DIS: st_nxt.filter_r = st_r.filter_r & ~wmask;
        pin_io_pkg::OFF_OUT_SET: st_nxt.out_data_r = st_r.out_data_r | wmask;
        pin_io_pkg::OFF_OUT_CLR: st_nxt.out_data_r = st_r.out_data_r & ~wmask;
        pin_io_pkg::OFF_IRQ_EN: st_nxt.mask_r = st_r.mask_r | wmask;
        pin_io_pkg::OFF_IRQ_DIS: st_nxt.mask_r = st_r.mask_r & ~wmask;
        pin_io_pkg::OFF_OD_EN: st_nxt.od_r = st_r.od_r | wmask;
        pin_io_pkg::OFF_OD_DIS: st_nxt.od_r = st_r.od_r & ~wmask;
        default: st_nxt.od_r = st_r.od_r; // Read-only or unmapped: ignored
      endcase
    end
    // Read mux; unmapped reads return zero. Data is zero outside the
    // answer cycle so a stale value is never mistaken for an answer.
    st_nxt.rdata_r = pin_io_pkg::UNMAPPED_READ;
    if (rd_take)
    begin
      unique case (AVS_ADDRESS)
        pin_io_pkg::OFF_CTRL_SEL_STATE: st_nxt.rdata_r = st_r.ctrl_sel_r;
        pin_io_pkg::OFF_DRIVE_STATE: st_nxt.rdata_r = st_r.drive_en_r;
        pin_io_pkg::OFF_FILTER_STATE: st_nxt.rdata_r = st_r.filter_r;
        pin_io_pkg::OFF_OUT_STATE: st_nxt.rdata_r = st_r.out_data_r;
        pin_io_pkg::OFF_PIN_STATE: st_nxt.rdata_r = st_r.sync2_r;
        pin_io_pkg::OFF_IRQ_MASK: st_nxt.rdata_r = st_r.mask_r;
        pin_io_pkg::OFF_CHG_STATUS: st_nxt.rdata_r = st_r.chg_r;
        pin_io_pkg::OFF_OD_STATE: st_nxt.rdata_r = st_r.od_r;
        default: st_nxt.rdata_r = pin_io_pkg::UNMAPPED_READ;
      endcase
    end
    // Change status: read clears, a new edge in the same cycle wins
    // Only the bits handed to software are cleared: an edge that arrived
    // after the capture edge stays pending for the next read
    if (rd_hit && AVS_ADDRESS == pin_io_pkg::OFF_CHG_STATUS)
    begin
      st_nxt.chg_r = st_r.chg_r & ~st_r.rdata_r;
    end
    st_nxt.chg_r = st_nxt.chg_r | (filt_in ^ st_r.filt_prev_r);
    // Interrupt from status gated by mask
    st_nxt.irq_r = |(st_nxt.chg_r & st_nxt.mask_r);
  end

  // State register, synchronous reset.
  // Reset gives the pins to the peripherals and clears every latch; the
  // synchroniser also clears, so the first samples after reset may log
  // changes for pins that idle high.
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      st_r <= '0;
      st_r.ctrl_sel_r <= pin_io_pkg::RST_CTRL_SEL;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops, AVS_WAITREQUEST through one inverter.
  // No pad output passes through logic after the state register, which keeps
  // pad timing independent of the bus decode.
  assign AVS_READDATA = st_r.rdata_r;
  assign AVS_WAITREQUEST = !st_r.ack_r;
  assign PIN_OUT = st_r.pin_out_r;
  assign PIN_OE = st_r.pin_oe_r;
  assign PERIPH_IN = st_r.periph_in_r;
  assign IRQ = st_r.irq_r;

  // Checks.
  // Each check guards one rule next to the logic above. Write checks use
  // full byte lanes only, since partial lanes legally leave bits alone.
  // Checks that compare a registered output against $past of internal
  // state are one cycle deep because every output is one flop away.
  // All are disabled while reset is low; after release their $past values of state
  // come from the reset state, which satisfies every consequent but that of chk_pin_read.
  // The read checks watch the capture edge, not the answer edge, because
  // the data register loads on the edge that lifts the wait.
  // The handshake checks below cover both the waiting and idle bus.
  chk_set_latch: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_OUT_SET && AVS_BYTEENABLE == 4'hf
    |=> (st_r.out_data_r & $past(AVS_WRITEDATA)) == $past(AVS_WRITEDATA))
    else $error("set output did not set latch");
  chk_clr_latch: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_OUT_CLR && AVS_BYTEENABLE == 4'hf
    |=> (st_r.out_data_r & $past(AVS_WRITEDATA)) == 32'h0)
    else $error("clear output did not clear latch");
  chk_filt_dis: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_FILTER_DIS && AVS_BYTEENABLE == 4'hf
    |=> (st_r.filter_r & $past(AVS_WRITEDATA)) == 32'h0)
    else $error("filter disable failed");
  chk_mask_en: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_IRQ_EN && AVS_BYTEENABLE == 4'hf
    |=> (st_r.mask_r & $past(AVS_WRITEDATA)) == $past(AVS_WRITEDATA))
    else $error("irq enable failed");
  chk_edge_sticky: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (filt_in != st_r.filt_prev_r) |=> (st_r.chg_r & $past(filt_in ^ st_r.filt_prev_r))
    == $past(filt_in ^ st_r.filt_prev_r))
    else $error("edge not recorded");
  chk_irq_level: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    IRQ == |(st_r.chg_r & st_r.mask_r))
    else $error("irq not status and mask");
  chk_periph_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 ((PERIPH_IN & $past(st_r.ctrl_sel_r)) == 32'h0))
    else $error("peripheral input not held low");
  chk_pin_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rd_take && AVS_ADDRESS == pin_io_pkg::OFF_PIN_STATE
    |=> AVS_READDATA == $past(PIN_IN, 3))
    else $error("pin level readback wrong");
  chk_wait_one: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("answer not in one cycle");

  // Handshake steps: a waiting request, then exactly one answer cycle
  sequence seq_req_waiting;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence seq_one_answer;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  chk_answer_once: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    seq_req_waiting |=> seq_one_answer)
    else $error("answer not a single cycle");

  // Read data is zero whenever no answer stands
  chk_rdata_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    AVS_WAITREQUEST |-> AVS_READDATA == 32'h0)
    else $error("read data outside answer");

  // An idle bus never sees an answer
  chk_wait_idle: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    !(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer without request");

  // Interrupt disable clears mask bits
  chk_mask_dis: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_IRQ_DIS && AVS_BYTEENABLE == 4'hf
    |=> (st_r.mask_r & $past(AVS_WRITEDATA)) == 32'h0)
    else $error("irq disable failed");

  // Filter enable selects filters
  chk_filt_en: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_FILTER_EN && AVS_BYTEENABLE == 4'hf
    |=> (st_r.filter_r & $past(AVS_WRITEDATA)) == $past(AVS_WRITEDATA))
    else $error("filter enable failed");

  // Open-drain enable selects open drain
  chk_od_en: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    wr_hit && AVS_ADDRESS == pin_io_pkg::OFF_OD_EN && AVS_BYTEENABLE == 4'hf
    |=> (st_r.od_r & $past(AVS_WRITEDATA)) == $past(AVS_WRITEDATA))
    else $error("open drain enable failed");

  // Output data status returns the latch
  chk_read_out: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rd_take && AVS_ADDRESS == pin_io_pkg::OFF_OUT_STATE
    |=> AVS_READDATA == $past(st_r.out_data_r))
    else $error("output data read wrong");

  // Mask read returns the enables
  chk_read_mask: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rd_take && AVS_ADDRESS == pin_io_pkg::OFF_IRQ_MASK
    |=> AVS_READDATA == $past(st_r.mask_r))
    else $error("mask read wrong");

  // Change status read returns the sticky bits
  chk_read_chg: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rd_take && AVS_ADDRESS == pin_io_pkg::OFF_CHG_STATUS
    |=> AVS_READDATA == $past(st_r.chg_r))
    else $error("change status read wrong");

  // Reported bits clear when no new edge arrives
  chk_chg_clear: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    rd_hit && AVS_ADDRESS == pin_io_pkg::OFF_CHG_STATUS && filt_in == st_r.filt_prev_r
    |=> (st_r.chg_r & $past(st_r.rdata_r)) == 32'h0)
    else $error("change status not cleared");

  // Owned pins show the output latch
  chk_pin_follow: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 (((PIN_OUT ^ $past(st_r.out_data_r)) & $past(st_r.ctrl_sel_r)) == 32'h0))
    else $error("pad does not follow latch");

  // Owned open-drain pins never drive a one
  chk_od_release: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 ((PIN_OE & $past(st_r.ctrl_sel_r & st_r.od_r & st_r.out_data_r)) == 32'h0))
    else $error("open drain drove high");

  // Owned pins drive only with output enable
  chk_oe_gate: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 ((PIN_OE & $past(st_r.ctrl_sel_r & ~st_r.drive_en_r)) == 32'h0))
    else $error("pad driven without enable");

  // Second stage reads only the first
  chk_sync_chain: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 (st_r.sync2_r == $past(st_r.sync1_r)))
    else $error("synchroniser chain broken");

  // Filter level moves only on two equal samples
  chk_pulse_reject: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 (((st_r.filt_r ^ $past(st_r.filt_r)) &
    ($past(st_r.sync2_r) ^ $past(st_r.prev_r))) == 32'h0))
    else $error("filter passed a glitch");

  // Unfiltered pins take the raw synchronised level
  chk_filter_bypass: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ((filt_in ^ st_r.sync2_r) & ~st_r.filter_r) == 32'h0)
    else $error("filter not bypassed");

  // Peripheral pins see the selected input path
  chk_periph_path: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    ##1 (((PERIPH_IN ^ $past(filt_in)) & ~$past(st_r.ctrl_sel_r)) == 32'h0))
    else $error("peripheral input path wrong");
endmodule // pin_io_data_irq_control
`default_nettype wire

// >>> src/pin_io_pkg.sv
// Package for the 32-line parallel I/O block: register map, reset values,
// bus and pin carrier structs.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package pin_io_pkg;
  localparam int unsigned NUM_PINS = 32;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_SEL_EN = 8'h00;
  localparam logic [7:0] OFF_CTRL_SEL_DIS = 8'h04;
  localparam logic [7:0] OFF_CTRL_SEL_STATE = 8'h08;
  localparam logic [7:0] OFF_DRIVE_EN = 8'h10;
  localparam logic [7:0] OFF_DRIVE_DIS = 8'h14;
  localparam logic [7:0] OFF_DRIVE_STATE = 8'h18;
  localparam logic [7:0] OFF_FILTER_EN = 8'h20;
  localparam logic [7:0] OFF_FILTER_DIS = 8'h24;
  localparam logic [7:0] OFF_FILTER_STATE = 8'h28;
  localparam logic [7:0] OFF_OUT_SET = 8'h30;
  localparam logic [7:0] OFF_OUT_CLR = 8'h34;
  localparam logic [7:0] OFF_OUT_STATE = 8'h38;
  localparam logic [7:0] OFF_PIN_STATE = 8'h3c;
  localparam logic [7:0] OFF_IRQ_EN = 8'h40;
  localparam logic [7:0] OFF_IRQ_DIS = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFF_CHG_STATUS = 8'h4c;
  localparam logic [7:0] OFF_OD_EN = 8'h50;
  localparam logic [7:0] OFF_OD_DIS = 8'h54;
  localparam logic [7:0] OFF_OD_STATE = 8'h58;
  // Reset values
  localparam logic [31:0] RST_CTRL_SEL = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Avalon-MM request from master
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } bus_req_s;

  // Pin side group (one bit per pin)
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pin_drive_s;
endpackage
